// ### common/pvn_pkg.sv
/*
  Shared constants and types for the peripheral vector number registers:
  register offsets, field positions, reset value, source codes, APB carriers.
  Assumes a 32-bit APB with an 8-bit byte address and a single core clock.
*/
package pvn_pkg;

  // geometry
  localparam int unsigned PVN_NUM_REGS = 5;
  localparam int unsigned PVN_NUM_SRC  = 10;
  localparam int unsigned PVN_VEC_W    = 7;
  localparam int unsigned PVN_REG_W    = 16;

  // field positions inside each 16-bit vector register
  localparam int unsigned PVN_HI_MSB  = 14;
  localparam int unsigned PVN_HI_LSB  = 8;
  localparam int unsigned PVN_LO_MSB  = 6;
  localparam int unsigned PVN_LO_LSB  = 0;
  localparam int unsigned PVN_RSV_HI  = 15;
  localparam int unsigned PVN_RSV_LO  = 7;

  // reset value of every vector register
  localparam logic [15:0] PVN_VREG_RESET = 16'h0000;

  // byte offsets: t1 compare, t1 counter, t2 compare, t2 counter, serial1 rx
  localparam logic [7:0] PVN_VREG_OFS [PVN_NUM_REGS] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  localparam logic [7:0] PVN_OFS_STATUS = 8'h14;

  // status word layout
  localparam int unsigned PVN_STAT_VEC_LSB = 0;
  localparam int unsigned PVN_STAT_SRC_LSB = 8;
  localparam int unsigned PVN_STAT_STBY    = 16;
  localparam int unsigned PVN_STAT_BAD     = 17;

  // interrupt sources; register k holds source 2k (high) and 2k+1 (low)
  typedef enum logic [3:0] {
    PVN_SRC_T1_MATCH_A = 4'h0,
    PVN_SRC_T1_MATCH_B = 4'h1,
    PVN_SRC_T1_OVF     = 4'h2,
    PVN_SRC_T1_UNF     = 4'h3,
    PVN_SRC_T2_MATCH_A = 4'h4,
    PVN_SRC_T2_MATCH_B = 4'h5,
    PVN_SRC_T2_OVF     = 4'h6,
    PVN_SRC_T2_UNF     = 4'h7,
    PVN_SRC_SER1_ERR   = 4'h8,
    PVN_SRC_SER1_RXF   = 4'h9
  } pvn_src_t;

  typedef logic [PVN_NUM_SRC-1:0][PVN_VEC_W-1:0] pvn_vec_tbl_t;

  typedef enum logic [1:0] {
    PVN_ST_IDLE = 2'b01,
    PVN_ST_ACK  = 2'b10
  } pvn_apb_st_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } pvn_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } pvn_apb_rsp_t;

endpackage : pvn_pkg

// ### src/pvn_vec_reg.sv
/*
  One 16-bit vector setting register with two 7-bit vector fields.
  Assumes the parent qualifies wr_en with a completed APB write.
*/
`timescale 1ns/100ps
module pvn_vec_reg
  import pvn_pkg::*;
(
  input  wire logic        core_clk, // core clock
  input  wire logic        reset,    // sync reset, active high
  input  wire logic        wr_en,    // completed write to this register
  input  wire logic [1:0]  wr_strb,  // byte lanes 1 and 0
  input  wire logic [15:0] wr_data,  // low half of write data
  output logic      [15:0] rd_data,  // read view, reserved bits zero
  output logic      [6:0]  hi_vec,   // field in bits 14:8
  output logic      [6:0]  lo_vec    // field in bits 6:0
);

  typedef struct packed {
    logic [6:0] hi;
    logic [6:0] lo;
  } pvn_vreg_st_t;

  pvn_vreg_st_t state_r;
  pvn_vreg_st_t state_nxt;

  // each lane writes its own field; bits 15 and 7 are never stored
  always_comb begin
    state_nxt = state_r;
    if (wr_en && wr_strb[1]) begin
      state_nxt.hi = wr_data[PVN_HI_MSB:PVN_HI_LSB];
    end
    if (wr_en && wr_strb[0]) begin
      state_nxt.lo = wr_data[PVN_LO_MSB:PVN_LO_LSB];
    end
  end

  // no standby input here: contents only change by write or reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= {PVN_VREG_RESET[PVN_HI_MSB:PVN_HI_LSB], PVN_VREG_RESET[PVN_LO_MSB:PVN_LO_LSB]};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rd_data = {1'b0, state_r.hi, 1'b0, state_r.lo};
  assign hi_vec  = state_r.hi;
  assign lo_vec  = state_r.lo;

endmodule : pvn_vec_reg

// ### src/pvn_vec_select.sv
/*
  Presents the programmed vector number for an accepted interrupt source.
  Assumes accept requests come from logic on core_clk, one per cycle at most.
*/
`timescale 1ns/100ps
module pvn_vec_select
  import pvn_pkg::*;
(
  input  wire logic               core_clk,     // core clock
  input  wire logic               reset,        // sync reset, active high
  input  wire logic               standby,      // block asleep, no answers
  input  wire logic               accept_valid, // source accepted this cycle
  input  wire logic [3:0]         accept_src,   // accepted source code
  input  wire pvn_pkg::pvn_vec_tbl_t vec_tbl,   // programmed vectors
  output logic                    vec_valid_r,  // one-cycle answer strobe
  output logic                    vec_bad_r,    // one-cycle bad source strobe
  output logic      [6:0]         vec_num_r,    // last presented vector
  output logic      [3:0]         last_src_r    // last answered source
);

  typedef struct packed {
    logic       valid;
    logic       bad;
    logic [6:0] num;
    logic [3:0] src;
  } pvn_sel_st_t;

  pvn_sel_st_t state_r;
  pvn_sel_st_t state_nxt;

  // look up live table so a write just before acceptance is honoured
  always_comb begin
    state_nxt       = state_r;
    state_nxt.valid = 1'b0;
    state_nxt.bad   = 1'b0;
    if (accept_valid && !standby) begin
      if (accept_src < 4'(PVN_NUM_SRC)) begin
        state_nxt.valid = 1'b1;
        state_nxt.num   = vec_tbl[accept_src];
        state_nxt.src   = accept_src;
      end else begin
        state_nxt.bad = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign vec_valid_r = state_r.valid;
  assign vec_bad_r   = state_r.bad;
  assign vec_num_r   = state_r.num;
  assign last_src_r  = state_r.src;

endmodule : pvn_vec_select

// ### src/pvn_vector_regs.sv
/*
  Peripheral vector number registers: five 16-bit APB-mapped registers that
  assign 7-bit vectors to ten timer and serial interrupt sources, plus the
  lookup that answers the CPU side when a source is accepted.
  Assumes an APB master on core_clk and same-clock accept/standby signals.
*/
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
module pvn_vector_regs
  import pvn_pkg::*;
(
  input  wire logic                 core_clk,     // core clock, 100 MHz
  input  wire logic                 reset,        // sync reset, active high
  input  wire pvn_pkg::pvn_apb_req_t apb_req,     // APB request group
  output pvn_pkg::pvn_apb_rsp_t     apb_rsp,      // APB answer group
  input  wire logic                 standby,      // standby mode level
  input  wire logic                 accept_valid, // source accepted strobe
  input  wire logic [3:0]           accept_src,   // accepted source code
  output logic                      vec_valid,    // vector answer strobe
  output logic                      vec_bad,      // unknown source strobe
  output logic      [6:0]           vec_num       // presented vector number
);

  typedef struct packed {
    pvn_apb_st_t  st;
    pvn_apb_rsp_t rsp;
  } pvn_top_st_t;

  pvn_top_st_t state_r;
  pvn_top_st_t state_nxt;

  pvn_vec_tbl_t           vec_tbl;
  logic [PVN_NUM_REGS-1:0] vreg_hit;
  logic [PVN_NUM_REGS-1:0] wr_en;
  logic [15:0]            vreg_rd [PVN_NUM_REGS];
  logic                   stat_hit;
  logic                   addr_hit;
  logic                   wr_fire;
  logic [31:0]            rd_word;
  logic [31:0]            stat_word;
  logic [3:0]             last_src;
  logic                   bad_seen_r;

  // write takes effect only on the edge where pready is sampled high
  assign wr_fire  = apb_req.psel && apb_req.penable && apb_req.pwrite && state_r.rsp.pready;
  assign stat_hit = (apb_req.paddr == PVN_OFS_STATUS);
  assign addr_hit = (|vreg_hit) || stat_hit;

  // one register per pair of sources; high field takes the even source
  for (genvar k = 0; k < PVN_NUM_REGS; k++) begin : g_vreg
    assign vreg_hit[k] = (apb_req.paddr == PVN_VREG_OFS[k]);
    assign wr_en[k]    = wr_fire && vreg_hit[k];
    pvn_vec_reg u_reg (
      .core_clk (core_clk),
      .reset    (reset),
      .wr_en    (wr_en[k]),
      .wr_strb  (apb_req.pstrb[1:0]),
      .wr_data  (apb_req.pwdata[15:0]),
      .rd_data  (vreg_rd[k]),
      .hi_vec   (vec_tbl[2*k]),
      .lo_vec   (vec_tbl[2*k+1])
    );
  end

  // answer path to the CPU side
  pvn_vec_select u_sel (
    .core_clk     (core_clk),
    .reset        (reset),
    .standby      (standby),
    .accept_valid (accept_valid),
    .accept_src   (accept_src),
    .vec_tbl      (vec_tbl),
    .vec_valid_r  (vec_valid),
    .vec_bad_r    (vec_bad),
    .vec_num_r    (vec_num),
    .last_src_r   (last_src)
  );

  // sticky record of a bad source code, cleared by reading status
  always_ff @(posedge core_clk) begin
    if (reset) begin
      bad_seen_r <= 1'b0;
    end else if (vec_bad) begin
      bad_seen_r <= 1'b1;                   // set wins over read clear
    end else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite && stat_hit) begin
      bad_seen_r <= 1'b0;
    end
  end

  // status shows what the block last presented and its mode
  always_comb begin
    stat_word = 32'h0;
    stat_word[PVN_STAT_VEC_LSB +: PVN_VEC_W] = vec_num;
    stat_word[PVN_STAT_SRC_LSB +: 4] = last_src;
    stat_word[PVN_STAT_STBY] = standby;
    stat_word[PVN_STAT_BAD]  = bad_seen_r;
  end

  // read mux; upper half of a vector word always reads zero
  always_comb begin
    rd_word = stat_hit ? stat_word : 32'h0;
    for (int i = 0; i < PVN_NUM_REGS; i++) begin
      if (vreg_hit[i]) begin
        rd_word = {16'h0, vreg_rd[i]};
      end
    end
  end

  // zero-wait slave: setup cycle primes pready for the access cycle
  always_comb begin
    state_nxt            = state_r;
    state_nxt.rsp.pready = 1'b0;
    unique case (state_r.st)
      PVN_ST_IDLE: begin
        if (apb_req.psel && !apb_req.penable) begin
          state_nxt.st          = PVN_ST_ACK;
          state_nxt.rsp.pready  = 1'b1;
          state_nxt.rsp.pslverr = !addr_hit;
          state_nxt.rsp.prdata  = apb_req.pwrite ? 32'h0 : rd_word;
        end
      end
      PVN_ST_ACK: begin
        state_nxt.st = PVN_ST_IDLE;
      end
      default: begin
        state_nxt.st = PVN_ST_IDLE;         // recover from a corrupted code
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r    <= '0;
      state_r.st <= PVN_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign apb_rsp = state_r.rsp;

  // helpers read only by the checks below
  logic [6:0] sel_vec;
  logic       src_ok;
  always_comb begin
    src_ok  = (accept_src < 4'(PVN_NUM_SRC));
    sel_vec = 7'h00;
    if (src_ok) begin
      sel_vec = vec_tbl[accept_src];
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // reset leaves every field at zero on the next edge
  property p_reset_clear;
    @(posedge core_clk) disable iff (1'b0)
    reset |=> (vec_tbl == '0) && !apb_rsp.pready && !vec_valid;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("vector registers not zero after reset");

  // without a write the table holds, standby or not
  property p_standby_hold;
    (wr_en == '0) |=> $stable(vec_tbl);
  endproperty
  a_standby_hold: assert property (p_standby_hold)
    else $error("vector table changed without a write");

  // standby toggling alone leaves the table unchanged over two cycles
  property p_standby_edge;
    ($changed(standby) && wr_en == '0) ##1 (wr_en == '0) |=> $stable(vec_tbl);
  endproperty
  a_standby_edge: assert property (p_standby_edge)
    else $error("vector table disturbed around standby change");

  // reserved bits and upper half never read as one outside a status read
  property p_reserved_zero;
    apb_rsp.pready && !stat_hit |-> (apb_rsp.prdata[PVN_RSV_HI] == 1'b0)
      && (apb_rsp.prdata[PVN_RSV_LO] == 1'b0) && (apb_rsp.prdata[31:16] == 16'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit read back as one");

  // full write to timer1 compare lands in both fields
  property p_t1_cmp_wr;
    wr_en[0] && apb_req.pstrb[1:0] == 2'b11 |=>
      vec_tbl[PVN_SRC_T1_MATCH_A] == $past(apb_req.pwdata[PVN_HI_MSB:PVN_HI_LSB]) &&
      vec_tbl[PVN_SRC_T1_MATCH_B] == $past(apb_req.pwdata[PVN_LO_MSB:PVN_LO_LSB]);
  endproperty
  a_t1_cmp_wr: assert property (p_t1_cmp_wr)
    else $error("timer1 compare vectors not written");

  property p_t1_cnt_wr;
    wr_en[1] && apb_req.pstrb[1:0] == 2'b11 |=>
      vec_tbl[PVN_SRC_T1_OVF] == $past(apb_req.pwdata[PVN_HI_MSB:PVN_HI_LSB]) &&
      vec_tbl[PVN_SRC_T1_UNF] == $past(apb_req.pwdata[PVN_LO_MSB:PVN_LO_LSB]);
  endproperty
  a_t1_cnt_wr: assert property (p_t1_cnt_wr)
    else $error("timer1 counter vectors not written");

  property p_t2_cmp_wr;
    wr_en[2] && apb_req.pstrb[1:0] == 2'b11 |=>
      vec_tbl[PVN_SRC_T2_MATCH_A] == $past(apb_req.pwdata[PVN_HI_MSB:PVN_HI_LSB]) &&
      vec_tbl[PVN_SRC_T2_MATCH_B] == $past(apb_req.pwdata[PVN_LO_MSB:PVN_LO_LSB]);
  endproperty
  a_t2_cmp_wr: assert property (p_t2_cmp_wr)
    else $error("timer2 compare vectors not written");

  property p_t2_cnt_wr;
    wr_en[3] && apb_req.pstrb[1:0] == 2'b11 |=>
      vec_tbl[PVN_SRC_T2_OVF] == $past(apb_req.pwdata[PVN_HI_MSB:PVN_HI_LSB]) &&
      vec_tbl[PVN_SRC_T2_UNF] == $past(apb_req.pwdata[PVN_LO_MSB:PVN_LO_LSB]);
  endproperty
  a_t2_cnt_wr: assert property (p_t2_cnt_wr)
    else $error("timer2 counter vectors not written");

  property p_ser1_wr;
    wr_en[4] && apb_req.pstrb[1:0] == 2'b11 |=>
      vec_tbl[PVN_SRC_SER1_ERR] == $past(apb_req.pwdata[PVN_HI_MSB:PVN_HI_LSB]) &&
      vec_tbl[PVN_SRC_SER1_RXF] == $past(apb_req.pwdata[PVN_LO_MSB:PVN_LO_LSB]);
  endproperty
  a_ser1_wr: assert property (p_ser1_wr)
    else $error("serial1 receive vectors not written");

  // a read of timer1 compare shows both fields in place
  property p_readback;
    apb_req.psel && !apb_req.penable && !apb_req.pwrite && vreg_hit[0] |=>
      apb_rsp.pready && apb_rsp.prdata[15:0] == {1'b0, $past(vec_tbl[0]), 1'b0, $past(vec_tbl[1])};
  endproperty
  a_readback: assert property (p_readback)
    else $error("register read does not match stored fields");

  // accepted source answered next cycle with its programmed vector
  property p_accept_vec;
    accept_valid && !standby && src_ok |=> vec_valid && vec_num == $past(sel_vec);
  endproperty
  a_accept_vec: assert property (p_accept_vec)
    else $error("accepted source got wrong vector");

  // no answer while in standby or for a bad code; a bad code is flagged only outside standby
  property p_no_answer;
    accept_valid && (standby || !src_ok) |=> !vec_valid ##0 (vec_bad == !$past(standby));
  endproperty
  a_no_answer: assert property (p_no_answer)
    else $error("answer given in standby or for unknown source");

  // every setup cycle is answered in the following cycle
  property p_apb_ready;
    apb_req.psel && !apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready ##1 !apb_rsp.pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("apb access not answered in one cycle");

  c_full_write: cover property (wr_en[4] ##1 accept_valid && accept_src == PVN_SRC_SER1_RXF);
  c_read_back:  cover property (apb_req.psel && !apb_req.pwrite ##1 apb_rsp.pready && !apb_rsp.pslverr);
  c_standby:    cover property (standby && accept_valid ##1 !vec_valid);
  c_bad_addr:   cover property (apb_rsp.pready && apb_rsp.pslverr);

endmodule : pvn_vector_regs

// ### verif/pvn_cpu_model.sv
/*
  CPU-side model: issues one-cycle accept pulses on request and catches
  the vector answer, which stands for a single cycle only.
  Assumes the bench raises go for one cycle per accept.
*/
`timescale 1ns/100ps
module pvn_cpu_model
  import pvn_pkg::*;
(
  input  wire logic       core_clk,     // core clock
  input  wire logic       reset,        // sync reset, active high
  input  wire logic       go,           // bench asks for one accept
  input  wire logic [3:0] src,          // source code to accept
  input  wire logic       vec_valid,    // vector answer strobe
  input  wire logic       vec_bad,      // bad source strobe
  input  wire logic [6:0] vec_num,      // presented vector
  output logic            accept_valid, // accept pulse
  output logic      [3:0] accept_src,   // accepted source code
  output logic            seen_valid,   // answer caught since last go
  output logic            seen_bad,     // bad flag caught since last go
  output logic      [6:0] seen_num      // vector caught with answer
);
  // accept driver and answer catcher
  always_ff @(posedge core_clk) begin
    if (reset) begin
      accept_valid <= 1'b0;
      accept_src   <= 4'h0;
      seen_valid   <= 1'b0;
      seen_bad     <= 1'b0;
      seen_num     <= 7'h00;
    end else begin
      accept_valid <= go;
      // idle code keeps changing so a stale code never looks valid
      accept_src <= go ? src : ~accept_src;
      seen_valid <= go ? 1'b0 : (seen_valid | vec_valid);
      seen_bad   <= go ? 1'b0 : (seen_bad | vec_bad);
      if (vec_valid) begin
        seen_num <= vec_num;
      end
    end
  end
endmodule : pvn_cpu_model

// ### verif/pvn_vector_regs_tb.sv
/*
  Self-checking bench for the vector number registers: APB tasks,
  accepts through the CPU model, reset, reserved bits, standby, errors.
  Assumes the zero-wait APB slave and one-cycle accept answer of the design.
*/
`timescale 1ns/100ps
module pvn_vector_regs_tb;
  import pvn_pkg::*;
  logic         core_clk;
  logic         reset;
  logic         standby;
  logic         go;
  logic [3:0]   src;
  pvn_apb_req_t req;
  pvn_apb_rsp_t rsp;
  logic         accept_valid;
  logic [3:0]   accept_src;
  logic         vec_valid;
  logic         vec_bad;
  logic [6:0]   vec_num;
  logic         seen_valid;
  logic         seen_bad;
  logic [6:0]   seen_num;
  logic [31:0]  rd;
  logic         er;
  logic [6:0]   hv [5];
  logic [6:0]   lv [5];
  int           errors;
  int           compares;
  int           cycles;

  pvn_vector_regs pvn_vector_regs_inst (
    .core_clk(core_clk), .reset(reset), .apb_req(req), .apb_rsp(rsp), .standby(standby),
    .accept_valid(accept_valid), .accept_src(accept_src), .vec_valid(vec_valid),
    .vec_bad(vec_bad), .vec_num(vec_num)
  );
  pvn_cpu_model pvn_cpu_model_inst (
    .core_clk(core_clk), .reset(reset), .go(go), .src(src), .vec_valid(vec_valid),
    .vec_bad(vec_bad), .vec_num(vec_num), .accept_valid(accept_valid), .accept_src(accept_src),
    .seen_valid(seen_valid), .seen_bad(seen_bad), .seen_num(seen_num)
  );

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // hang guard, tests need well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles >= 5000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, seen, exp);
    end
  endtask : check

  // one APB transfer; holds the request until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge core_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: s};
    @(posedge core_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      $display("[ERR] %0t no pready", $time);
    end
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    req.pwdata  <= ~d;
  endtask : xfer

  // one accept; the model holds the answer for the check
  task automatic acc(input logic [3:0] s);
    @(posedge core_clk);
    go  <= 1'b1;
    src <= s;
    @(posedge core_clk);
    go <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : acc

  task automatic read_all(input logic zero, input string what);
    for (int k = 0; k < 5; k++) begin
      xfer(1'b0, PVN_VREG_OFS[k], 32'h0, 4'h0);
      check(rd, zero ? 32'h0 : {17'h0, hv[k], 1'b0, lv[k]}, what);
      check(er, 1'b0, what);
    end
  endtask : read_all

  task automatic finish_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    reset   = 1'b1;
    standby = 1'b0;
    go      = 1'b0;
    src     = 4'h0;
    req     = '0;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    read_all(1'b1, "reset value");
    check(vec_num, 7'h00, "reset vector");
    $display("test reset done");
    // all ones, reserved and upper bits must drop
    for (int k = 0; k < 5; k++) begin
      xfer(1'b1, PVN_VREG_OFS[k], 32'hffffffff, 4'hf);
      xfer(1'b0, PVN_VREG_OFS[k], 32'h0, 4'h0);
      check(rd, 32'h00007f7f, "reserved bits");
    end
    $display("test reserved done");
    // distinct vectors per field, reserved bits written zero
    for (int k = 0; k < 5; k++) begin
      hv[k] = 7'(22 * k + 5);
      lv[k] = 7'(22 * k + 16);
      xfer(1'b1, PVN_VREG_OFS[k], {17'h0, hv[k], 1'b0, lv[k]}, 4'h3);
    end
    read_all(1'b0, "readback");
    for (int s = 0; s < 10; s++) begin
      acc(4'(s));
      check(seen_valid, 1'b1, "answer");
      check(seen_num, s[0] ? lv[s/2] : hv[s/2], "vector");
    end
    $display("test mapping done");
    // low lane only touches the low field
    lv[0] = 7'h01;
    xfer(1'b1, PVN_VREG_OFS[0], 32'h00007f01, 4'h1);
    acc(4'h1);
    check(seen_num, 7'h01, "strobe lo");
    acc(4'h0);
    check(seen_num, hv[0], "strobe hi");
    $display("test strobe done");
    // standby refuses accepts but keeps contents
    standby <= 1'b1;
    acc(4'h4);
    check(seen_valid, 1'b0, "standby answer");
    check(seen_bad, 1'b0, "standby bad");
    standby <= 1'b0;
    read_all(1'b0, "after standby");
    acc(4'h9);
    check(seen_num, lv[4], "wake vector");
    $display("test standby done");
    // bad source code and unmapped address
    acc(4'hc);
    check(seen_bad, 1'b1, "bad flag");
    check(seen_valid, 1'b0, "bad answer");
    check(vec_num, lv[4], "bad keeps vector");
    // status: sticky bad flag, last source 9, last vector; the read clears the flag
    xfer(1'b0, PVN_OFS_STATUS, 32'h0, 4'h0);
    check(rd, {14'h0, 1'b1, 1'b0, 4'h0, 4'h9, 1'b0, lv[4]}, "status bad set");
    xfer(1'b0, PVN_OFS_STATUS, 32'h0, 4'h0);
    check(rd, {14'h0, 1'b0, 1'b0, 4'h0, 4'h9, 1'b0, lv[4]}, "status bad clear");
    xfer(1'b0, 8'h18, 32'h0, 4'h0);
    check(er, 1'b1, "unmapped err");
    check(rd, 32'h0, "unmapped data");
    $display("test errors done");
    // second reset in mid-run
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    read_all(1'b1, "second reset");
    check(vec_num, 7'h00, "second reset vector");
    $display("test rereset done");
    finish_test();
  end
endmodule : pvn_vector_regs_tb
